// [address_phase_and_bit20_mask_test.sv]
// Self-checking bench for the address phase and bit-20 mask block
`timescale 1ns/10ps
`include "apm_cfg.svh"
module address_phase_and_bit20_mask_test import apm_pkg::*;;
  logic sysClk = 1'b0;
  logic rst_n = 1'b0;
  logic bit20MaskIn_n = 1'b1;
  apm_addr_t coreAddr = '0;
  logic linkStrobeClk, linkRst_n, addrValidStrobe_n, rxValid, rxParityErr, maskActive;
  logic [1:0] addrParityPair_n;
  apm_addr_t addrLines_n, maskedAddr, rxAddr, rxType;
  logic [7:0] powerOnCfg;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  apm_addr_phase apm_addr_phase_inst (.sysClk(sysClk), .rst_n(rst_n),
    .linkStrobeClk(linkStrobeClk), .linkRst_n(linkRst_n), .addrLines_n(addrLines_n),
    .addrParityPair_n(addrParityPair_n), .addrValidStrobe_n(addrValidStrobe_n),
    .bit20MaskIn_n(bit20MaskIn_n), .coreAddr(coreAddr), .maskedAddr(maskedAddr),
    .rxAddr(rxAddr), .rxType(rxType), .rxValid(rxValid), .rxParityErr(rxParityErr),
    .powerOnCfg(powerOnCfg), .maskActive(maskActive));
  apm_bus_agent apm_bus_agent_inst (.linkStrobeClk(linkStrobeClk), .linkRst_n(linkRst_n),
    .addrLines_n(addrLines_n), .addrParityPair_n(addrParityPair_n),
    .addrValidStrobe_n(addrValidStrobe_n));
  // ==========
  // Clock, hang guard, helpers
  always #25 sysClk = ~sysClk;
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  task automatic check(input string what, input apm_addr_t exp, input apm_addr_t got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail = n_fail + 1;
    end
  endtask
  task automatic wait_rx(output int n);
    n = 0;
    repeat (12) begin
      @(negedge sysClk);
      if (rxValid === 1'b1) n = n + 1;
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    // Link reset needs strobe edges; it ends inside the 16 system cycles
    apm_bus_agent_inst.reset_link();
    repeat (7) @(negedge sysClk);
    check("rxValid in reset", '0, apm_addr_t'(rxValid));
    check("maskActive in reset", '0, apm_addr_t'(maskActive));
    rst_n = 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_rereset();
    int n;
    @(negedge sysClk);
    rst_n = 1'b0;
    repeat (2) @(negedge sysClk);
    check("powerOnCfg in reset", '0, apm_addr_t'(powerOnCfg));
    check("rxValid in reset", '0, apm_addr_t'(rxValid));
    rst_n = 1'b1;
    // Old toggle still stands on the link side: no phantom phase
    wait_rx(n);
    check("rxValid after reset", '0, apm_addr_t'(n));
    apm_bus_agent_inst.send(35'h0_0000_003c, 35'h0_0000_0011, 1'b1, 2'h0);
    wait_rx(n);
    check("rxValid count", 35'h1, apm_addr_t'(n));
    check("powerOnCfg retaken", 35'h3c, apm_addr_t'(powerOnCfg));
    check("rxType", 35'h11, rxType);
    $display("t_rereset done");
  endtask
  task automatic t_phases();
    apm_addr_t a [4] = '{35'h4_1234_56a5, 35'h3_0f0f_00ff, 35'h1_8000_0001, 35'h7_ffff_fffe};
    apm_addr_t k [4] = '{35'h0_0000_0015, 35'h2_aaaa_5555, 35'h5_0000_0003, 35'h0_0000_0007};
    logic [1:0] f [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    int n;
    int j;
    // Last phase has no valid strobe: outputs must hold
    for (int i = 0; i < 4; i++) begin
      apm_bus_agent_inst.send(a[i], k[i], i < 3, f[i]);
      wait_rx(n);
      j = (i < 3) ? i : 2;
      check("rxValid count", apm_addr_t'(i < 3), apm_addr_t'(n));
      check("rxAddr", a[j], rxAddr);
      check("rxType", k[j], rxType);
      check("rxParityErr", apm_addr_t'(f[j] != 2'h0), apm_addr_t'(rxParityErr));
      check("powerOnCfg", apm_addr_t'(a[0][7:0]), apm_addr_t'(powerOnCfg));
    end
    $display("t_phases done");
  endtask
  task automatic t_mask();
    coreAddr = 35'h0_0002_0000;
    repeat (4) @(negedge sysClk);
    check("maskedAddr open", coreAddr, maskedAddr);
    // Real mode only, and settled well before any write that relies on it
    bit20MaskIn_n = 1'b0;
    @(negedge sysClk);
    check("maskActive early", '0, apm_addr_t'(maskActive));
    repeat (4) @(negedge sysClk);
    check("maskActive", 35'h1, apm_addr_t'(maskActive));
    check("maskedAddr wrap", '0, maskedAddr);
    coreAddr = 35'h0_0003_1234;
    @(negedge sysClk);
    check("maskedAddr alias", 35'h0_0001_1234, maskedAddr);
    bit20MaskIn_n = 1'b1;
    repeat (5) @(negedge sysClk);
    check("maskedAddr released", coreAddr, maskedAddr);
    $display("t_mask done");
  endtask
  initial begin
    t_reset();
    t_phases();
    t_rereset();
    t_mask();
    finish_test();
  end
endmodule // address_phase_and_bit20_mask_test

// [apm_addr_phase.sv]
// Address phase capture, parity check, strap sampling and bit-20 masking
`timescale 1ns/10ps
`include "apm_cfg.svh"
module apm_addr_phase
  import apm_pkg::*;
(
  // System clock and reset
  input wire logic sysClk,
  input wire logic rst_n,
  // Link side: strobe-clocked pins, active low
  input wire logic linkStrobeClk,
  input wire logic linkRst_n,
  input wire logic [`APM_ADDR_W-1:0] addrLines_n,
  input wire logic [1:0] addrParityPair_n,
  input wire logic addrValidStrobe_n,
  // Legacy mask input, asynchronous, active low
  input wire logic bit20MaskIn_n,
  // Internal requester
  input wire logic [`APM_ADDR_W-1:0] coreAddr,
  output logic [`APM_ADDR_W-1:0] maskedAddr,
  // Captured transaction
  output logic [`APM_ADDR_W-1:0] rxAddr,
  output logic [`APM_TYPE_W-1:0] rxType,
  output logic rxValid,
  output logic rxParityErr,
  // Power-on configuration and live mask status
  output logic [`APM_CFG_W-1:0] powerOnCfg,
  output logic maskActive
);
  // ==========================================================
  // Link domain: capture on both strobe edges
  // ==========================================================
  logic [`APM_ADDR_W-1:0] riseAddr_q;
  logic [1:0] risePar_q;
  logic riseValid_q;
  logic [`APM_ADDR_W-1:0] fallType_q;
  logic phaseTog_q;
  logic [`APM_ADDR_W-1:0] holdAddr_q;
  logic [`APM_TYPE_W-1:0] holdType_q;
  logic holdPerr_q;
  wire [`APM_ADDR_W-1:0] addrTrue = ~addrLines_n;
  wire [1:0] parTrue = ~addrParityPair_n;
  wire validTrue = ~addrValidStrobe_n;

  // First sub-phase on rising edge: address, parity, valid
  always_ff @(posedge linkStrobeClk) begin
    if (!linkRst_n) begin
      riseAddr_q <= '0;
      risePar_q <= '0;
      riseValid_q <= 1'b0;
    end else begin
      riseAddr_q <= addrTrue;
      risePar_q <= parTrue;
      riseValid_q <= validTrue;
    end
  end

  // Second sub-phase on falling edge: transaction type
  always_ff @(negedge linkStrobeClk) begin
    if (!linkRst_n) begin
      fallType_q <= '0;
    end else begin
      fallType_q <= addrTrue;
    end
  end

  // Even parity per half, sender-generated, checked here
  wire parLoBad = ^{riseAddr_q[`APM_PAR_SPLIT-1:0], risePar_q[0]};
  wire parHiBad = ^{riseAddr_q[`APM_ADDR_W-1:`APM_PAR_SPLIT], risePar_q[1]};

  // Bundle held stable, toggle announces it; sys side samples after sync
  always_ff @(posedge linkStrobeClk) begin
    if (!linkRst_n) begin
      holdAddr_q <= '0;
      holdType_q <= '0;
      holdPerr_q <= 1'b0;
      phaseTog_q <= 1'b0;
    end else if (riseValid_q) begin
      holdAddr_q <= riseAddr_q;
      holdType_q <= fallType_q;
      holdPerr_q <= parLoBad | parHiBad;
      phaseTog_q <= ~phaseTog_q;
    end
  end

  // ==========================================================
  // Crossing into system domain
  // ==========================================================
  logic togSync;
  logic togSeen_q;
  logic maskSync;
  logic cfgTaken_q;
  logic [1:0] settle_q;
  // A toggle left from before a system-only reset must not look new;
  // a phase landing inside this settle window is dropped
  wire settled = (settle_q == `APM_SETTLE_CYC);
  wire [1:0] settle_d = settled ? settle_q : settle_q + 2'h1;
  wire newPhase = settled && (togSync ^ togSeen_q);

  apm_sync #(.WIDTH(1)) uTogSync (
    .clk(sysClk),
    .rstN(rst_n),
    .dIn(phaseTog_q),
    .dOut(togSync)
  );

  // Mask pin is asynchronous; never read before two flops
  apm_sync #(.WIDTH(1)) uMaskSync (
    .clk(sysClk),
    .rstN(rst_n),
    .dIn(~bit20MaskIn_n),
    .dOut(maskSync)
  );

  // ==========================================================
  // System domain outputs
  // ==========================================================
  wire [`APM_ADDR_W-1:0] maskVec = {{(`APM_ADDR_W-`APM_MASK_BIT+`APM_ADDR_LSB-1){1'b1}},
    1'b0, {(`APM_MASK_BIT-`APM_ADDR_LSB){1'b1}}};
  wire [`APM_ADDR_W-1:0] maskedD = maskSync ? (coreAddr & maskVec) : coreAddr;

  always_ff @(posedge sysClk) begin
    if (!rst_n) begin
      togSeen_q <= 1'b0;
      settle_q <= 2'h0;
      rxAddr <= '0;
      rxType <= '0;
      rxValid <= 1'b0;
      rxParityErr <= 1'b0;
      maskedAddr <= '0;
      maskActive <= 1'b0;
    end else begin
      togSeen_q <= togSync;
      settle_q <= settle_d;
      rxValid <= newPhase;
      maskedAddr <= maskedD;
      maskActive <= maskSync;
      if (newPhase) begin
        rxAddr <= holdAddr_q;
        rxType <= holdType_q;
        rxParityErr <= holdPerr_q;
      end
    end
  end

  // Straps: first address phase after reset fixes configuration
  always_ff @(posedge sysClk) begin
    if (!rst_n) begin
      cfgTaken_q <= 1'b0;
      powerOnCfg <= '0;
    end else if (newPhase && !cfgTaken_q) begin
      cfgTaken_q <= 1'b1;
      powerOnCfg <= holdAddr_q[`APM_CFG_W-1:0];
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_mask_bit20;
    @(posedge sysClk) disable iff (!rst_n)
      maskSync |=> !maskedAddr[`APM_MASK_BIT-`APM_ADDR_LSB];
  endproperty
  a_mask_bit20: assert property (p_mask_bit20) else $error("bit 20 not masked");

  property p_mask_pass;
    @(posedge sysClk) disable iff (!rst_n)
      !maskSync |=> maskedAddr == $past(coreAddr);
  endproperty
  a_mask_pass: assert property (p_mask_pass) else $error("address altered unmasked");

  property p_mask_sync;
    @(posedge sysClk) disable iff (!rst_n)
      $rose(maskActive) |-> $past(~bit20MaskIn_n, 3);
  endproperty
  a_mask_sync: assert property (p_mask_sync) else $error("mask rose too early");

  property p_rx_pulse;
    @(posedge sysClk) disable iff (!rst_n)
      rxValid |=> !rxValid || newPhase;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("valid stuck");

  property p_rx_addr;
    @(posedge sysClk) disable iff (!rst_n)
      newPhase |=> rxValid && rxAddr == $past(holdAddr_q);
  endproperty
  a_rx_addr: assert property (p_rx_addr) else $error("address not delivered");

  property p_rx_type;
    @(posedge sysClk) disable iff (!rst_n)
      newPhase |=> rxType == $past(holdType_q);
  endproperty
  a_rx_type: assert property (p_rx_type) else $error("type not delivered");

  property p_parity;
    @(posedge linkStrobeClk) disable iff (!linkRst_n)
      riseValid_q && (parLoBad || parHiBad) |=> holdPerr_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error missed");

  property p_cfg_hold;
    @(posedge sysClk) disable iff (!rst_n)
      cfgTaken_q |=> $stable(powerOnCfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");

  property p_cfg_take;
    @(posedge sysClk) disable iff (!rst_n)
      newPhase && !cfgTaken_q |=> powerOnCfg == $past(holdAddr_q[`APM_CFG_W-1:0]);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("config not taken");

  property p_rx_hold;
    @(posedge sysClk) disable iff (!rst_n)
      !newPhase |=> $stable(rxAddr) && $stable(rxType) && $stable(rxParityErr);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("captured phase not held");

  property p_mask_clear;
    @(posedge sysClk) disable iff (!rst_n)
      $fell(maskActive) |-> !$past(~bit20MaskIn_n, 3);
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask fell too early");

  property p_tog_step;
    @(posedge linkStrobeClk) disable iff (!linkRst_n)
      riseValid_q |=> phaseTog_q != $past(phaseTog_q);
  endproperty
  a_tog_step: assert property (p_tog_step) else $error("phase not announced");

  property p_type_take;
    @(posedge linkStrobeClk) disable iff (!linkRst_n)
      riseValid_q |=> holdType_q == $past(fallType_q);
  endproperty
  a_type_take: assert property (p_type_take) else $error("type not taken on fall");

  c_phase: cover property (@(posedge sysClk) disable iff (!rst_n) rxValid);
  c_perr: cover property (@(posedge sysClk) disable iff (!rst_n) rxValid && rxParityErr);
  c_mask: cover property (@(posedge sysClk) disable iff (!rst_n) $rose(maskActive));
  c_cfg: cover property (@(posedge sysClk) disable iff (!rst_n) $rose(cfgTaken_q));
endmodule // apm_addr_phase

// [apm_bus_agent.sv]
// Far-side bus agent model driving the strobed address link
`timescale 1ns/10ps
`include "apm_cfg.svh"
module apm_bus_agent (
  // Link pins, active low
  output logic linkStrobeClk,
  output logic linkRst_n,
  output logic [`APM_ADDR_W-1:0] addrLines_n,
  output logic [1:0] addrParityPair_n,
  output logic addrValidStrobe_n
);
  initial begin
    linkStrobeClk = 1'b0;
    linkRst_n = 1'b0;
    addrLines_n = '1;
    addrParityPair_n = 2'h3;
    addrValidStrobe_n = 1'b1;
  end
  // ==========
  // Strobe runs only inside frames
  task automatic pulse();
    #40 linkStrobeClk = 1'b1;
    #80 linkStrobeClk = 1'b0;
    #40;
  endtask
  task automatic reset_link();
    linkRst_n = 1'b0;
    repeat (3) pulse();
    linkRst_n = 1'b1;
  endtask
  task automatic send(input logic [`APM_ADDR_W-1:0] a, input logic [`APM_ADDR_W-1:0] k,
                      input logic v, input logic [1:0] flip);
    addrLines_n = ~a;
    addrValidStrobe_n = ~v;
    addrParityPair_n = ~({^a[34:24], ^a[23:0]} ^ flip);
    #40 linkStrobeClk = 1'b1;
    #40 addrLines_n = ~k;
    addrValidStrobe_n = 1'b1;
    #40 linkStrobeClk = 1'b0;
    #80 linkStrobeClk = 1'b1;
    #80 linkStrobeClk = 1'b0;
    // Released lines must not keep looking valid
    addrLines_n = ~addrLines_n;
    addrParityPair_n = ~addrParityPair_n;
  endtask
endmodule // apm_bus_agent

// [apm_cfg.svh]
// Constants for the address phase and bit-20 mask block
`ifndef APM_CFG_SVH
`define APM_CFG_SVH
`define APM_ADDR_MSB 37
`define APM_ADDR_LSB 3
`define APM_ADDR_W 35
`define APM_TYPE_W 35
`define APM_MASK_BIT 20
`define APM_PAR_SPLIT 24
`define APM_CFG_LSB 3
`define APM_CFG_W 8
`define APM_SYNC_STAGES 2
`define APM_SETTLE_CYC 2'h3
`endif

// [apm_pkg.sv]
// Types for the address phase and bit-20 mask block
`include "apm_cfg.svh"
package apm_pkg;
  typedef logic [`APM_ADDR_W-1:0] apm_addr_t;
  typedef enum logic {APM_SUB_ADDR, APM_SUB_TYPE} apm_sub_t;
endpackage

// [apm_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/10ps
module apm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Data
  input wire logic [WIDTH-1:0] dIn,
  output logic [WIDTH-1:0] dOut
);
  logic [WIDTH-1:0] meta_q;

  // Zero width would leave nothing to synchronise
  if (WIDTH < 1) begin : gBadWidth
    $error("apm_sync WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      meta_q <= '0;
      dOut <= '0;
    end else begin
      meta_q <= dIn;
      dOut <= meta_q;
    end
  end
endmodule // apm_sync
